// ### core/cia_pkg.sv
// package of constants, types and state layout for the core interrupt arbiter
package cia_pkg;
   // register file addresses of the interrupt registers
   localparam logic [7:0] CIA_ADDR_CENTRAL   = 8'hE6; // central_irq_control
   localparam logic [7:0] CIA_ADDR_EDGE      = 8'hF2; // external_edge_select
   localparam logic [7:0] CIA_ADDR_EXT_PEND  = 8'hF3; // external_pending_flags
   localparam logic [7:0] CIA_ADDR_EXT_MASK  = 8'hF4; // external_mask_flags
   localparam logic [7:0] CIA_ADDR_PAIR_PRIO = 8'hF5; // external_pair_priority
   localparam logic [7:0] CIA_ADDR_NEST      = 8'hF7; // nested_level_stack (hold levels)
   localparam logic [7:0] CIA_ADDR_PER_CTRL0 = 8'hF8; // peripheral channel 0 control
   localparam logic [7:0] CIA_ADDR_PER_VEC0  = 8'hFA; // peripheral channel 0 vector
   // reset values
   localparam logic [7:0] CIA_RST_CENTRAL    = 8'h87;
   localparam logic [7:0] CIA_RST_EDGE       = 8'h00;
   localparam logic [7:0] CIA_RST_EXT_PEND   = 8'h00;
   localparam logic [7:0] CIA_RST_EXT_MASK   = 8'h00;
   localparam logic [7:0] CIA_RST_PAIR_PRIO  = 8'hFF;
   localparam logic [4:0] CIA_RST_PER_CTRL   = 5'h1C; // pending 0, mask 0, level 7
   // central register field positions
   localparam int CIA_BIT_GLOBAL_COUNTER_ENABLE = 7;
   localparam int CIA_BIT_TOP_LEVEL_PENDING = 6;
   localparam int CIA_BIT_TLI  = 5;
   localparam int CIA_BIT_IEN  = 4;
   localparam int CIA_BIT_IAM  = 3;
   // peripheral control field positions
   localparam int CIA_PER_PEND = 0;
   localparam int CIA_PER_MASK = 1;
   localparam int CIA_PER_PRL  = 2;
   // channel counts and levels
   localparam int          CIA_N_EXT   = 8;
   localparam int          CIA_N_PER   = 2;
   localparam int          CIA_N_CH    = 10;
   localparam logic [2:0]  CIA_LVL_LOW = 3'h7;
   // timing in core clocks
   localparam logic [2:0]  CIA_ARB_LAST  = 3'h4; // sampling period 5 cycles
   localparam logic [4:0]  CIA_MCYC_BASE = 5'h12; // 18 cycles
   localparam logic [4:0]  CIA_MCYC_RF   = 5'h02;
   localparam logic [4:0]  CIA_MCYC_CSR  = 5'h02;
   localparam logic [4:0]  CIA_MCYC_WAKE = 5'h01;
   localparam logic [6:0]  CIA_EXT_VEC_BASE = 7'h40; // base of external vectors
   // arbiter states
   typedef enum logic [1:0] {
      CIA_IDLE = 2'b00,
      CIA_ACK  = 2'b01,
      CIA_HOLD = 2'b10,
      CIA_MCYC = 2'b11
   } cia_state_t;
   // register access group
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } cia_regreq_t;
   // instruction flow signals from the core
   typedef struct packed {
      logic wrote;      // current instruction already performed a write
      logic instr_end;  // current instruction completes this cycle
      logic iret;       // return from interrupt executes
      logic ei;         // irq_on_instruction
      logic di;         // irq_off_instruction
      logic in_wait;    // core is in wait-for-interrupt
      logic stack_rf;   // system stack lives in register file
      logic cs_push;    // code_seg_push_enable
   } cia_core_t;
   // complete state of the arbiter
   typedef struct packed {
      logic [7:0]      s1, s2, s3, lvl;     // external pin synchronisers, stable level
      logic            t1, t2, t3, tlvl;    // top level pin synchroniser
      logic [7:0]      edge_sel, ext_pend, ext_mask, pair_prio;
      logic            global_counter_enable, top_level_pending, top_level_mask_select, global_irq_enable, arbitration_mode_select;
      logic [2:0]      current_priority_level;
      logic [6:0]      hold;
      logic [1:0][4:0] per_ctrl;
      logic [1:0][6:0] per_vec;
      cia_state_t      st;
      logic [2:0]      arb_cnt;
      logic [4:0]      cyc_cnt;
      logic [9:0]      sampled;
      logic            win_tl;
      logic [3:0]      win_idx;
      logic [2:0]      win_prl;
      logic            tl_active;
      logic [7:0]      rdata;
      logic            ack, abort, start;
      logic [6:0]      vector;
      logic            busy;
   } cia_state_s_t;
endpackage

// ### core/cia_top.sv
// core interrupt arbiter: channel flags, arbitration, acknowledge sequencing
`timescale 1ns/1ps
module cia_top (
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire cia_pkg::cia_regreq_t reg_req,      // register file access
   output logic [7:0]                reg_rdata,    // registered read data
   input  wire logic [7:0]           ext_pin,      // external interrupt pins
   input  wire logic                 tl_pin,       // top level source pin
   input  wire logic                 tl_rising,    // top level edge select
   input  wire logic                 tl_unmask,    // top_level_unmaskable
   input  wire logic [1:0]           per_event,    // peripheral trigger events
   input  wire cia_pkg::cia_core_t   core_in,      // instruction flow from core
   output logic                      irq_ack,      // request acknowledged
   output logic                      instr_abort,  // abort current instruction
   output logic                      isr_start,    // service routine starts
   output logic [6:0]                vector_ptr,   // vector_pointer of winner
   output logic                      mcyc_busy,    // interrupt machine cycle runs or waits for instr_end
   output logic                      timer_enable  // global_counter_enable
);

   cia_pkg::cia_state_s_t r_reg;   // registered state
   cia_pkg::cia_state_s_t r_next;  // next state

   logic [9:0]      req;           // live request per channel
   logic [9:0][2:0] channel_priority_field;           // level per channel
   logic            tl_req;        // top level request
   logic            found;         // arbitration found a winner
   logic [3:0]      pick_idx;      // winner index
   logic [2:0]      pick_prl;      // winner level
   logic [7:0]      ext_rise;      // qualified external edges
   logic            tl_edge;       // qualified top level edge
   logic [4:0]      mcyc_len;      // machine cycle length

   // winner among requests: lowest level number, lowest index on ties
   function automatic logic [7:0] cia_pick(input logic [9:0] rq,
                                           input logic [9:0][2:0] lv,
                                           input logic [2:0] cur);
      logic       hit;
      logic [3:0] idx;
      logic [2:0] best;
      hit  = 1'b0;
      idx  = 4'h0;
      best = cia_pkg::CIA_LVL_LOW;
      for (int i = 0; i < cia_pkg::CIA_N_CH; i++) begin
         // level 7 can never beat the current level, so it is never taken
         if (rq[i] && (lv[i] < cur) && (!hit || (lv[i] < best))) begin
            hit  = 1'b1;
            idx  = 4'(i);
            best = lv[i];
         end
      end
      return {hit, idx, best};
   endfunction

   // lowest set hold bit is the most recently suspended level
   function automatic logic [2:0] cia_pop(input logic [6:0] hold);
      logic [2:0] lvl;
      lvl = cia_pkg::CIA_LVL_LOW;
      for (int i = 6; i >= 0; i--) begin
         if (hold[i]) begin
            lvl = 3'(i);
         end
      end
      return lvl;
   endfunction

   // request and level map of all channels
   always_comb begin
      for (int i = 0; i < cia_pkg::CIA_N_EXT; i++) begin
         // pair bits form the upper level, channel parity the lsb
         channel_priority_field[i] = {r_reg.pair_prio[(i/2)*2+1], r_reg.pair_prio[(i/2)*2], 1'(i % 2)};
         req[i] = r_reg.ext_pend[i] && r_reg.ext_mask[i] && r_reg.global_irq_enable;
      end
      for (int j = 0; j < cia_pkg::CIA_N_PER; j++) begin
         channel_priority_field[cia_pkg::CIA_N_EXT+j] = r_reg.per_ctrl[j][cia_pkg::CIA_PER_PRL +: 3];
         req[cia_pkg::CIA_N_EXT+j] = r_reg.per_ctrl[j][cia_pkg::CIA_PER_PEND]
                                   && r_reg.per_ctrl[j][cia_pkg::CIA_PER_MASK]
                                   && r_reg.global_irq_enable;
      end
      // maskable form needs the global enable, unmaskable form only pending
      tl_req = r_reg.top_level_pending && ((r_reg.top_level_mask_select && r_reg.global_irq_enable) || tl_unmask);
      {found, pick_idx, pick_prl} = cia_pick(r_reg.sampled, channel_priority_field, r_reg.current_priority_level);
   end

   // edge qualification: a change counts once the second and third stages agree
   always_comb begin
      for (int i = 0; i < cia_pkg::CIA_N_EXT; i++) begin
         // pin i feeds channel i, A0 at bit 0 up to D1 at bit 7
         ext_rise[i] = (r_reg.s2[i] == r_reg.s3[i]) && (r_reg.s3[i] != r_reg.lvl[i])
                     && (r_reg.s3[i] == r_reg.edge_sel[i]);
      end
      tl_edge = (r_reg.t2 == r_reg.t3) && (r_reg.t3 != r_reg.tlvl) && (r_reg.t3 == tl_rising);
   end

   // machine cycle length from stack placement, code segment push and wake-up
   always_comb begin
      mcyc_len = cia_pkg::CIA_MCYC_BASE;
      if (core_in.stack_rf) begin
         mcyc_len = mcyc_len + cia_pkg::CIA_MCYC_RF;
      end
      if (core_in.cs_push) begin
         mcyc_len = mcyc_len + cia_pkg::CIA_MCYC_CSR;
      end
      if (core_in.in_wait) begin
         mcyc_len = mcyc_len + cia_pkg::CIA_MCYC_WAKE;
      end
   end

   // next state: software writes first, hardware effects after so sets win
   always_comb begin
      r_next       = r_reg;
      r_next.ack   = 1'b0;
      r_next.abort = 1'b0;
      r_next.start = 1'b0;
      // synchronisers, first stage read only by the second
      r_next.s1 = ext_pin;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.t1 = tl_pin;
      r_next.t2 = r_reg.t1;
      r_next.t3 = r_reg.t2;
      if (r_reg.s2 == r_reg.s3) begin
         r_next.lvl = r_reg.s3;
      end else begin
         r_next.lvl = r_reg.lvl;
      end
      for (int i = 0; i < cia_pkg::CIA_N_EXT; i++) begin
         if (r_reg.s2[i] == r_reg.s3[i]) begin
            r_next.lvl[i] = r_reg.s3[i];
         end
      end
      if (r_reg.t2 == r_reg.t3) begin
         r_next.tlvl = r_reg.t3;
      end

      // software register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            cia_pkg::CIA_ADDR_CENTRAL: begin
               r_next.global_counter_enable = reg_req.wdata[cia_pkg::CIA_BIT_GLOBAL_COUNTER_ENABLE];
               // software may only set the top level pending flag
               r_next.top_level_pending = r_reg.top_level_pending | reg_req.wdata[cia_pkg::CIA_BIT_TOP_LEVEL_PENDING];
               r_next.top_level_mask_select  = reg_req.wdata[cia_pkg::CIA_BIT_TLI];
               // direct enable writes are safe only while disabled
               r_next.global_irq_enable  = reg_req.wdata[cia_pkg::CIA_BIT_IEN];
               r_next.arbitration_mode_select  = reg_req.wdata[cia_pkg::CIA_BIT_IAM];
               r_next.current_priority_level  = reg_req.wdata[2:0];
            end
            cia_pkg::CIA_ADDR_EDGE:      r_next.edge_sel  = reg_req.wdata;
            cia_pkg::CIA_ADDR_EXT_PEND:  r_next.ext_pend  = reg_req.wdata;
            cia_pkg::CIA_ADDR_EXT_MASK:  r_next.ext_mask  = reg_req.wdata;
            cia_pkg::CIA_ADDR_PAIR_PRIO: r_next.pair_prio = reg_req.wdata;
            cia_pkg::CIA_ADDR_NEST:      r_next.hold      = reg_req.wdata[6:0];
            default: begin
               // peripheral control and vector pairs sit above the fixed map
               for (int j = 0; j < cia_pkg::CIA_N_PER; j++) begin
                  if (reg_req.addr == cia_pkg::CIA_ADDR_PER_CTRL0 + 8'(j)) begin
                     r_next.per_ctrl[j] = reg_req.wdata[4:0];
                  end
                  if (reg_req.addr == cia_pkg::CIA_ADDR_PER_VEC0 + 8'(j)) begin
                     r_next.per_vec[j] = reg_req.wdata[6:0];
                  end
               end
            end
         endcase
      end

      // enable and disable instructions
      if (core_in.ei) begin
         r_next.global_irq_enable = 1'b1;
      end
      if (core_in.di) begin
         r_next.global_irq_enable = 1'b0;
      end

      // return from interrupt
      if (core_in.iret) begin
         if (r_reg.tl_active) begin
            // top level return leaves enable and level untouched
            r_next.tl_active = 1'b0;
         end else begin
            r_next.global_irq_enable = 1'b1;
            if (r_reg.arbitration_mode_select) begin
               r_next.current_priority_level = cia_pop(r_reg.hold);
               if (cia_pop(r_reg.hold) != cia_pkg::CIA_LVL_LOW) begin
                  r_next.hold[cia_pop(r_reg.hold)] = 1'b0;
               end
            end
         end
      end

      // sampling cadence runs regardless of instruction flow
      if (r_reg.arb_cnt == cia_pkg::CIA_ARB_LAST) begin
         r_next.arb_cnt = 3'h0;
      end else begin
         r_next.arb_cnt = r_reg.arb_cnt + 3'h1;
      end
      if (r_reg.arb_cnt == 3'h0) begin
         r_next.sampled = req;
      end

      case (r_reg.st)
         cia_pkg::CIA_IDLE: begin
            // decision at the end of the five-cycle window; top level serviced alone
            if ((r_reg.arb_cnt == cia_pkg::CIA_ARB_LAST) && !r_reg.tl_active) begin
               if (tl_req) begin
                  r_next.win_tl = 1'b1;
                  r_next.st     = cia_pkg::CIA_ACK;
               end else if (found) begin
                  r_next.win_tl  = 1'b0;
                  r_next.win_idx = pick_idx;
                  r_next.win_prl = pick_prl;
                  r_next.st      = cia_pkg::CIA_ACK;
               end
            end
         end
         cia_pkg::CIA_ACK: begin
            // extra acknowledge cycle, abort in the same cycle only if nothing was written
            r_next.ack = 1'b1;
            if (!core_in.wrote) begin
               r_next.abort = 1'b1;
               r_next.st    = cia_pkg::CIA_MCYC;
            end else begin
               r_next.st = cia_pkg::CIA_HOLD;
            end
            r_next.cyc_cnt = mcyc_len - 5'h1;
            if (r_reg.win_tl) begin
               r_next.top_level_pending      = 1'b0;
               r_next.tl_active = 1'b1;
               r_next.vector    = cia_pkg::CIA_EXT_VEC_BASE - 7'h2;
            end else begin
               r_next.global_irq_enable = 1'b0;
               if (r_reg.arbitration_mode_select) begin
                  // old level pushed into the hold stack, winner becomes current
                  if (r_reg.current_priority_level != cia_pkg::CIA_LVL_LOW) begin
                     r_next.hold[r_reg.current_priority_level] = 1'b1;
                  end
                  r_next.current_priority_level = r_reg.win_prl;
               end
               if (r_reg.win_idx < 4'(cia_pkg::CIA_N_EXT)) begin
                  r_next.ext_pend[r_reg.win_idx[2:0]] = 1'b0;
                  r_next.vector = cia_pkg::CIA_EXT_VEC_BASE + {2'h0, r_reg.win_idx[2:0], 1'b0};
               end else begin
                  r_next.per_ctrl[r_reg.win_idx[0]][cia_pkg::CIA_PER_PEND] = 1'b0;
                  r_next.vector = r_reg.per_vec[r_reg.win_idx[0]];
               end
            end
         end
         cia_pkg::CIA_HOLD: begin
            // instruction already wrote: let it finish first
            if (core_in.instr_end) begin
               r_next.st = cia_pkg::CIA_MCYC;
            end
         end
         cia_pkg::CIA_MCYC: begin
            // stacking and vector fetch
            if (r_reg.cyc_cnt == 5'h0) begin
               r_next.start = 1'b1;
               r_next.st    = cia_pkg::CIA_IDLE;
            end else begin
               r_next.cyc_cnt = r_reg.cyc_cnt - 5'h1;
            end
         end
         default: r_next.st = cia_pkg::CIA_IDLE;
      endcase

      // hardware events last: an event in the clearing cycle is kept
      r_next.ext_pend = r_next.ext_pend | ext_rise;
      if (tl_edge) begin
         r_next.top_level_pending = 1'b1;
      end
      for (int j = 0; j < cia_pkg::CIA_N_PER; j++) begin
         if (per_event[j]) begin
            r_next.per_ctrl[j][cia_pkg::CIA_PER_PEND] = 1'b1;
         end
      end

      r_next.busy = (r_next.st == cia_pkg::CIA_MCYC) || (r_next.st == cia_pkg::CIA_HOLD);

      // registered read data follows the address every cycle
      case (reg_req.addr)
         cia_pkg::CIA_ADDR_CENTRAL:
            r_next.rdata = {r_reg.global_counter_enable, r_reg.top_level_pending, r_reg.top_level_mask_select, r_reg.global_irq_enable, r_reg.arbitration_mode_select, r_reg.current_priority_level};
         cia_pkg::CIA_ADDR_EDGE:      r_next.rdata = r_reg.edge_sel;
         cia_pkg::CIA_ADDR_EXT_PEND:  r_next.rdata = r_reg.ext_pend;
         cia_pkg::CIA_ADDR_EXT_MASK:  r_next.rdata = r_reg.ext_mask;
         cia_pkg::CIA_ADDR_PAIR_PRIO: r_next.rdata = r_reg.pair_prio;
         cia_pkg::CIA_ADDR_NEST:      r_next.rdata = {1'b0, r_reg.hold};
         default: begin
            r_next.rdata = 8'h00;
            for (int j = 0; j < cia_pkg::CIA_N_PER; j++) begin
               if (reg_req.addr == cia_pkg::CIA_ADDR_PER_CTRL0 + 8'(j)) begin
                  r_next.rdata = {3'h0, r_reg.per_ctrl[j]};
               end
               if (reg_req.addr == cia_pkg::CIA_ADDR_PER_VEC0 + 8'(j)) begin
                  r_next.rdata = {1'b0, r_reg.per_vec[j]};
               end
            end
         end
      endcase
   end

   // state register, constants only under reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r_reg           <= '0;
         r_reg.global_counter_enable      <= cia_pkg::CIA_RST_CENTRAL[cia_pkg::CIA_BIT_GLOBAL_COUNTER_ENABLE];
         r_reg.current_priority_level       <= cia_pkg::CIA_RST_CENTRAL[2:0];
         r_reg.edge_sel  <= cia_pkg::CIA_RST_EDGE;
         r_reg.ext_pend  <= cia_pkg::CIA_RST_EXT_PEND;
         r_reg.ext_mask  <= cia_pkg::CIA_RST_EXT_MASK;
         r_reg.pair_prio <= cia_pkg::CIA_RST_PAIR_PRIO;
         r_reg.per_ctrl  <= {cia_pkg::CIA_RST_PER_CTRL, cia_pkg::CIA_RST_PER_CTRL};
         r_reg.st        <= cia_pkg::CIA_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata    = r_reg.rdata;
   assign irq_ack      = r_reg.ack;
   assign instr_abort  = r_reg.abort;
   assign isr_start    = r_reg.start;
   assign vector_ptr   = r_reg.vector;
   assign mcyc_busy    = r_reg.busy;
   assign timer_enable = r_reg.global_counter_enable;

endmodule

// ### verification/cia_core_model.sv
// behavioural core model: ends instructions at a prompt or slow pace
`timescale 1ns/1ps
module cia_core_model (
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   input  wire logic               slow,    // long instructions when high
   input  wire cia_pkg::cia_core_t ctl,     // flow levels and pulses from the bench
   output cia_pkg::cia_core_t      core_o   // flow as the arbiter sees it
);
   logic [3:0] pace_reg; // cycles spent in the current instruction
   logic       last;     // final cycle of the instruction
   assign last = (pace_reg == (slow ? 4'h8 : 4'h1));
   // free-running instruction pacing; slow pace stresses the wait for instr_end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pace_reg <= 4'h0;
      end else begin
         pace_reg <= last ? 4'h0 : pace_reg + 4'h1;
      end
   end
   // enable bit moves by ei/di pulses, central register writes, iret and acknowledge; the bench issues di before restoring it
   always_comb begin
      core_o           = ctl;
      core_o.instr_end = last;
   end
endmodule

// ### verification/cia_top_sva.sv
// port assertions for the core interrupt arbiter
`timescale 1ns/1ps
module cia_top_sva (
   input wire logic                 sys_clk,
   input wire logic                 resetn,
   input wire cia_pkg::cia_regreq_t reg_req,
   input wire logic [7:0]           reg_rdata,
   input wire cia_pkg::cia_core_t   core_in,
   input wire logic                 irq_ack,
   input wire logic                 instr_abort,
   input wire logic                 isr_start,
   input wire logic [6:0]           vector_ptr,
   input wire logic                 mcyc_busy,
   input wire logic                 timer_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [7:0] gap_reg;  // cycles since last acknowledge, saturating
   logic       global_counter_enable_reg; // last value written to the timer enable bit
   logic       cwr;      // write to the central register
   assign cwr = reg_req.wr && reg_req.addr == 8'hE6;
   // helper counters; saturation keeps the first acknowledge legal
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gap_reg  <= 8'hFF;
         global_counter_enable_reg <= 1'b1;
      end else begin
         gap_reg  <= irq_ack ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hFF};
         global_counter_enable_reg <= cwr ? reg_req.wdata[7] : global_counter_enable_reg;
      end
   end
   AST_ACK_PULSE: assert property (irq_ack |=> !irq_ack)
      else $error("acknowledge longer than one cycle");
   AST_ABORT_ACK: assert property (instr_abort |-> irq_ack)
      else $error("abort without acknowledge");
   AST_ABORT_CLEAN: assert property (instr_abort |-> !$past(core_in.wrote))
      else $error("abort after a write");
   AST_ACK_GAP: assert property (irq_ack |-> gap_reg >= 8'h13)
      else $error("acknowledge inside a machine cycle");
   AST_START_LEN: assert property (isr_start |-> gap_reg >= 8'h11)
      else $error("routine start too early");
   AST_START_SOON: assert property (irq_ack |-> ##[17:200] isr_start)
      else $error("routine start missing");
   AST_START_BUSY: assert property (isr_start |-> $past(mcyc_busy))
      else $error("routine start outside machine cycle");
   AST_TIMER: assert property (cwr ##1 !cwr |=> timer_enable == global_counter_enable_reg)
      else $error("timer enable not following bit 7");
   AST_VEC_HOLD: assert property (!irq_ack && !$past(irq_ack) |-> $stable(vector_ptr))
      else $error("vector moved without acknowledge");
   AST_UNMAPPED: assert property (reg_req.addr == 8'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped address read non-zero");
endmodule
bind cia_top cia_top_sva cia_top_sva_i (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .core_in(core_in), .irq_ack(irq_ack), .instr_abort(instr_abort),
   .isr_start(isr_start), .vector_ptr(vector_ptr), .mcyc_busy(mcyc_busy),
   .timer_enable(timer_enable));

// ### verification/cia_top_tb.sv
// self-checking bench for the core interrupt arbiter
`timescale 1ns/1ps
module cia_top_tb;
   logic                 sys_clk, resetn, tl_pin, tl_rising, tl_unmask, slow;
   cia_pkg::cia_regreq_t reg_req;             // register access
   cia_pkg::cia_core_t   ctl, core_in;        // bench flow, flow after core model
   logic [7:0]           reg_rdata, ext_pin;
   logic [1:0]           per_event;           // peripheral trigger pulses
   logic                 irq_ack, instr_abort, isr_start, mcyc_busy, timer_enable;
   logic [6:0]           vector_ptr;
   int                   error_cnt = 0, checks_done = 0, cyc = 0;
   logic [7:0]           radr [6] = '{8'hE6, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'h00};
   logic [7:0]           rrst [6] = '{8'h87, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
   cia_top cia_top_i (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .ext_pin(ext_pin), .tl_pin(tl_pin), .tl_rising(tl_rising),
      .tl_unmask(tl_unmask), .per_event(per_event), .core_in(core_in), .irq_ack(irq_ack),
      .instr_abort(instr_abort), .isr_start(isr_start), .vector_ptr(vector_ptr),
      .mcyc_busy(mcyc_busy), .timer_enable(timer_enable));
   cia_core_model cia_core_model_i (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
      .ctl(ctl), .core_o(core_in));
   // 250 MHz core clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wr: 1'b1, wdata: d};
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask
   // read data is registered: valid one cycle after the address
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_req.addr <= a;
      @(posedge sys_clk);
      #1 chk(reg_rdata, exp);
   endtask
   // one-cycle flow pulse, bits are iret, ei, di
   task automatic pulse(input logic [2:0] m);
      @(posedge sys_clk);
      {ctl.iret, ctl.ei, ctl.di} <= m;
      @(posedge sys_clk);
      {ctl.iret, ctl.ei, ctl.di} <= 3'b000;
   endtask
   // wait for acknowledge, check abort and vector, then wait for routine start
   task automatic take(input logic [6:0] v, input logic ab);
      int n;
      n = 0;
      while (irq_ack !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk({7'h00, irq_ack}, 8'h01);
      chk({7'h00, instr_abort}, {7'h00, ab});
      @(posedge sys_clk);
      #1 chk({1'b0, vector_ptr}, {1'b0, v});
      n = 0;
      while (isr_start !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk({7'h00, isr_start}, 8'h01);
   endtask
   task automatic quiet(input int len);
      logic seen;
      seen = 1'b0;
      repeat (len) begin
         @(posedge sys_clk);
         #1 seen = seen | (irq_ack === 1'b1);
      end
      chk({7'h00, seen}, 8'h00);
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      {reg_req, ctl, ext_pin, tl_pin, tl_unmask, per_event, slow} = '0;
      tl_rising = 1'b1;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      foreach (radr[i]) rdc(radr[i], rrst[i]);
      wr(8'hF2, 8'hA5);
      rdc(8'hF2, 8'hA5);
      wr(8'hE6, 8'h07);
      repeat (2) @(posedge sys_clk);
      #1 chk({7'h00, timer_enable}, 8'h00);
      $display("test registers done");
      // rising edge on pin 0, pair A at levels 0 and 1
      wr(8'hF2, 8'h01);
      wr(8'hF5, 8'hFC);
      wr(8'hF4, 8'h03);
      wr(8'hE6, 8'h97);
      @(posedge sys_clk);
      ext_pin[0] <= 1'b1; // held far beyond one sample clock
      take(7'h40, 1'b1);
      rdc(8'hF3, 8'h00);
      rdc(8'hE6, 8'h87);
      pulse(3'b100);
      rdc(8'hE6, 8'h97);
      $display("test external done");
      // software pending on a masked channel, then unmask it mid-instruction
      wr(8'hF4, 8'h00);
      wr(8'hF3, 8'h02);
      quiet(40);
      rdc(8'hF3, 8'h02);
      @(posedge sys_clk);
      {ctl.wrote, slow} <= 2'b11;
      wr(8'hF4, 8'h02);
      take(7'h42, 1'b0);
      @(posedge sys_clk);
      {ctl.wrote, slow} <= 2'b00;
      pulse(3'b100);
      // lowest level is never taken
      wr(8'hF5, 8'hFF);
      wr(8'hF3, 8'h02);
      wr(8'hF4, 8'h02);
      quiet(30);
      wr(8'hF3, 8'h00);
      $display("test masking done");
      // current level 1: level 0 taken, equal level 1 left waiting
      wr(8'hF5, 8'hFC);
      pulse(3'b001);
      wr(8'hE6, 8'h91);
      wr(8'hF4, 8'h03);
      wr(8'hF3, 8'h03);
      take(7'h40, 1'b1);
      pulse(3'b100);
      quiet(30);
      wr(8'hF4, 8'h00);
      wr(8'hF3, 8'h00);
      // nested mode loads the taken level, return restores it
      pulse(3'b001);
      wr(8'hF5, 8'hF3);
      wr(8'hE6, 8'h9F);
      wr(8'hF4, 8'h04);
      wr(8'hF3, 8'h04);
      take(7'h44, 1'b1);
      rdc(8'hE6, 8'h88);
      pulse(3'b100);
      rdc(8'hE6, 8'h9F);
      $display("test levels done");
      // peripheral channel 0 at level 0
      pulse(3'b001);
      wr(8'hE6, 8'h97);
      wr(8'hFA, 8'h15);
      wr(8'hF8, 8'h02);
      @(posedge sys_clk);
      per_event[0] <= 1'b1;
      @(posedge sys_clk);
      per_event[0] <= 1'b0;
      take(7'h15, 1'b1);
      pulse(3'b100);
      // unmaskable top level keeps the global enable
      @(posedge sys_clk);
      {tl_unmask, tl_pin} <= 2'b11;
      take(7'h3E, 1'b1);
      rdc(8'hE6, 8'h97);
      pulse(3'b100);
      pulse(3'b001);
      rdc(8'hE6, 8'h87);
      pulse(3'b010);
      rdc(8'hE6, 8'h97);
      $display("test sources done");
      give_verdict();
   end
endmodule
